// File: rtl/fetch_issue_pipeline.sv
/*
  Front end and issue control of a seven-stage four-wide pipeline.
  Assumes an instruction cache answering in the fetch cycle with predecode,
  a branch predictor answering in the slot cycle, and in-order retirement.
*/
// Behaviour
// - Seven stages: fetch, slot, map, issue, register read, execute, cache access.
// - Fetch reads up to four aligned instructions and predictor tables together.
// - Predictor resolves at most one branch or jump per cycle.
// - Not-taken first branch: step later branches one every two cycles.
// - Line prediction field is next cycle's cache index.
// - On fill, line prediction is the next sequential line index.
// - Slot compares predictor index with line index; mismatch aborts and redirects.
// - A line misprediction costs exactly one bubble.
// - Trained line predictor wins for memory-format calls and jumps.
// - Fetch produces the full virtual fetch PC.
// - Both set tags checked; set miss aborts last two slots, refetches, retrains.
// - Four instructions per cycle from a 64KB two-way cache.
// - Map in order, execute out of order, retire in order.
// - Slot logic assigns integer work upper or lower; EELL becomes UULL.
// - Map gives each instruction a unique 8-bit in-flight tag.
// - Mapped instructions enter the issue queues within the map stage.
// - Integer queue: 20 entries, four issues per cycle.
// - Float queue: 15 entries, two issues per cycle.
// - Issued at n, silent at n+1, deleted at n+2.
// - Register read takes register file operands or bypassed results.
// - Loads read tags and data; stores read tags, data to store queue.
// - Integer operate results are written in stage 6.
`timescale 1ns/100ps
`include "fetch_defines.svh"
module fetch_issue_pipeline import fetch_pkg::*; (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  output logic [`IDX_W-1:0]                ic_index_o,
  output logic                             ic_set_o,
  output logic [`PC_W-1:0]                 virtual_fetch_pc_o,
  input  wire logic [`TAG_W-1:0]           ic_tag0_i,
  input  wire logic [`TAG_W-1:0]           ic_tag1_i,
  input  wire logic [`IDX_W-1:0]           ic_line_pred_i,
  input  wire logic                        ic_lp_true_i,
  input  wire logic                        ic_set_pred_i,
  input  wire kind_t [3:0]                 ic_kind_i,
  input  wire res_t [3:0]                  ic_res_i,
  input  wire logic [3:0]                  ic_branch_i,
  input  wire logic [3:0]                  ic_jump_to_subroutine_i,
  input  wire logic                        ic_fill_i,
  input  wire logic [`IDX_W-1:0]           ic_fill_index_i,
  output logic                             miss_o,
  input  wire logic                        bp_taken_i,
  input  wire logic [`PC_W-1:0]            bp_target_i,
  output logic                             lp_wr_o,
  output logic [`IDX_W-1:0]                lp_wr_index_o,
  output logic [`IDX_W-1:0]                lp_wr_value_o,
  output logic                             sp_wr_o,
  output logic [`IDX_W-1:0]                sp_wr_index_o,
  output logic                             sp_wr_set_o,
  output logic [3:0]                       slot_upper_o,
  input  wire logic [2:0]                  retire_cnt_i,
  input  wire logic                        ex_hold_i,
  output logic [`EX_LANES-1:0]             rf_rd_o,
  output logic [`EX_LANES-1:0][7:0]        rf_tag_o,
  input  wire logic [`EX_LANES-1:0][63:0]  rf_data_i,
  input  wire logic [`EX_LANES-1:0]        byp_hit_i,
  input  wire logic [`EX_LANES-1:0][63:0]  byp_data_i,
  output logic [`EX_LANES-1:0]             ex_valid_o,
  output logic [`EX_LANES-1:0][63:0]       ex_opnd_o,
  output logic [`EX_LANES-1:0]             dc_tag_rd_o,
  output logic [`EX_LANES-1:0]             dc_data_rd_o,
  output logic [`EX_LANES-1:0]             sq_wr_o,
  output logic [`EX_LANES-1:0]             wb_int_o,
  output logic [`EX_LANES-1:0][7:0]        dc_inum_o
);
  logic [`PC_W-1:0]   pc_q, pc_d, s1_pc_q, s1_pc_d, npc;
  logic               set_q, set_d, s1_lpt_q, s1_lpt_d;
  logic [1:0]         start_q, start_d, nstart, bslot;
  logic [3:0]         s1_v_q, s1_v_d, s1_br_q, s1_br_d, s1_jsr_q, s1_jsr_d;
  logic [3:0]         keep, brm, upto;
  kind_t [3:0]        s1_kind_q, s1_kind_d, s2_kind_q, s2_kind_d;
  res_t [3:0]         s1_res_q, s1_res_d;
  logic [`IDX_W-1:0]  s1_lp_q, s1_lp_d, bp_idx, s1_idx;
  logic               hit_p, hit_o, bfound, later, walk, mismatch, redir, stall, go;
  logic [3:0]         s2_v_q, s2_v_d, s2_up_q, s2_up_d;
  logic [7:0]         head_q, head_d;
  logic [8:0]         infl_q, infl_d;
  logic [2:0]         need, niq, nfq;
  logic [5:0]         s4_v, ex_v_q, ex_v_d, dc_v_q, dc_v_d;
  logic [5:0][7:0]    s4_tag, ex_tag_q, ex_tag_d, dc_tag_q, dc_tag_d;
  kind_t [5:0]        s4_kind, ex_kind_q, ex_kind_d, dc_kind_q, dc_kind_d;
  logic [5:0][63:0]   ex_op_q, ex_op_d;

  issue_if iq_bus ();
  issue_if fq_bus ();

  // Integer queue
  issue_queue #(.DEPTH(`IQ_DEPTH), .ISSUE(`IQ_ISSUE)) u_iq (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .port_io   (iq_bus.q)
  );
  // Float queue
  issue_queue #(.DEPTH(`FQ_DEPTH), .ISSUE(`FQ_ISSUE)) u_fq (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .port_io   (fq_bus.q)
  );

  function automatic logic [3:0] slot_upper(logic [3:0] v, res_t [3:0] r);
    logic [2:0] nu;
    logic [2:0] nl;
    logic [3:0] u;
    nu = '0;
    nl = '0;
    u = '0;
    for (int i = 0; i < 4; i++) begin
      if (v[i] && r[i] == RES_UPPER) nu = nu + 3'h1;
      if (v[i] && r[i] == RES_LOWER) nl = nl + 3'h1;
    end
    for (int i = 0; i < 4; i++) begin
      if (v[i]) begin
        case (r[i])
          RES_UPPER: u[i] = 1'b1;
          RES_FLEX: begin
            if (nu <= nl) begin
              u[i] = 1'b1;
              nu = nu + 3'h1;
            end else begin
              nl = nl + 3'h1;
            end
          end
          default: u[i] = 1'b0;
        endcase
      end
    end
    return u;
  endfunction

  // Stage 0 outputs: cache index, set and full fetch PC
  assign ic_index_o = pc_q[`IDX_MSB:`IDX_LSB];
  assign ic_set_o = set_q;
  assign virtual_fetch_pc_o = pc_q;
  // Both set tags checked on every access
  assign hit_p = (set_q ? ic_tag1_i : ic_tag0_i) == pc_q[`PC_W-1:`TAG_LSB];
  assign hit_o = (set_q ? ic_tag0_i : ic_tag1_i) == pc_q[`PC_W-1:`TAG_LSB];
  assign miss_o = !hit_p && !hit_o;
  assign s1_idx = s1_pc_q[`IDX_MSB:`IDX_LSB];
  assign redir = !stall && (|s1_v_q) && mismatch;

  // Slot-stage branch walk and fetch control
  always_comb begin
    brm = s1_br_q & s1_v_q;
    bfound = 1'b0;
    bslot = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (brm[i]) begin
        bfound = 1'b1;
        bslot = 2'(i);
      end
    end
    upto = (4'h2 << bslot) - 4'h1;
    later = |(brm & ~upto);
    keep = s1_v_q;
    walk = 1'b0;
    nstart = 2'h0;
    npc = s1_pc_q + 48'h10;
    bp_idx = npc[`IDX_MSB:`IDX_LSB];
    if (bfound) begin
      // One branch per cycle; later slots are dropped, refetched only when stepping to a later branch
      keep = s1_v_q & upto;
      if (s1_jsr_q[bslot] && s1_lpt_q) begin
        // Trained line target wins for memory-format jumps
        npc = {s1_pc_q[`PC_W-1:`TAG_LSB], s1_lp_q, 4'h0};
      end else if (bp_taken_i) begin
        npc = bp_target_i;
        nstart = bp_target_i[3:2];
      end else if (later) begin
        // Step to the next branch of the same line
        npc = s1_pc_q;
        nstart = bslot + 2'h1;
        walk = 1'b1;
      end
      bp_idx = npc[`IDX_MSB:`IDX_LSB];
    end
    // Predictor index against line index
    mismatch = walk || (bp_idx != s1_lp_q);
    pc_d = pc_q;
    set_d = set_q;
    start_d = start_q;
    s1_v_d = s1_v_q;
    s1_pc_d = s1_pc_q;
    s1_lp_d = s1_lp_q;
    s1_lpt_d = s1_lpt_q;
    s1_br_d = s1_br_q;
    s1_jsr_d = s1_jsr_q;
    s1_kind_d = s1_kind_q;
    s1_res_d = s1_res_q;
    lp_wr_o = 1'b0;
    lp_wr_index_o = s1_idx;
    lp_wr_value_o = bp_idx;
    sp_wr_o = 1'b0;
    sp_wr_index_o = pc_q[`IDX_MSB:`IDX_LSB];
    sp_wr_set_o = !set_q;
    if (!stall) begin
      s1_v_d = 4'h0;
      s1_pc_d = pc_q;
      s1_lp_d = ic_line_pred_i;
      s1_lpt_d = ic_lp_true_i;
      s1_br_d = ic_branch_i | ic_jump_to_subroutine_i;
      s1_jsr_d = ic_jump_to_subroutine_i;
      s1_kind_d = ic_kind_i;
      s1_res_d = ic_res_i;
      if (redir) begin
        // Drop this fetch, redirect: one bubble
        pc_d = npc;
        start_d = nstart;
        lp_wr_o = 1'b1;
      end else if (miss_o) begin
        pc_d = pc_q;
      end else if (!hit_p) begin
        // Set miss: keep first two slots, refetch rest, retrain
        s1_v_d = (4'hF << start_q) & 4'h3;
        set_d = !set_q;
        start_d = 2'h2;
        sp_wr_o = 1'b1;
      end else begin
        // Aligned group captured; line prediction is next index
        s1_v_d = 4'hF << start_q;
        pc_d = {pc_q[`PC_W-1:`TAG_LSB], ic_line_pred_i, 4'h0};
        set_d = ic_set_pred_i;
        start_d = 2'h0;
      end
    end
    if (ic_fill_i) begin
      // Fill seeds the next sequential line
      lp_wr_o = 1'b1;
      lp_wr_index_o = ic_fill_index_i;
      lp_wr_value_o = ic_fill_index_i + 11'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pc_q <= `RESET_PC;
      set_q <= 1'b0;
      start_q <= 2'h0;
      s1_v_q <= 4'h0;
      s1_pc_q <= '0;
      s1_lp_q <= '0;
      s1_lpt_q <= 1'b0;
      s1_br_q <= 4'h0;
      s1_jsr_q <= 4'h0;
      s1_kind_q <= {4{K_NOP}};
      s1_res_q <= {4{RES_NONE}};
    end else begin
      pc_q <= pc_d;
      set_q <= set_d;
      start_q <= start_d;
      s1_v_q <= s1_v_d;
      s1_pc_q <= s1_pc_d;
      s1_lp_q <= s1_lp_d;
      s1_lpt_q <= s1_lpt_d;
      s1_br_q <= s1_br_d;
      s1_jsr_q <= s1_jsr_d;
      s1_kind_q <= s1_kind_d;
      s1_res_q <= s1_res_d;
    end
  end

  // Map stage: tags and queue entry
  always_comb begin
    logic [2:0] ri;
    logic [2:0] rf;
    ri = 3'h0;
    rf = 3'h0;
    niq = 3'h0;
    nfq = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (s2_v_q[i] && is_float(s2_kind_q[i])) nfq = nfq + 3'h1;
      if (s2_v_q[i] && !is_float(s2_kind_q[i])) niq = niq + 3'h1;
    end
    need = niq + nfq;
    // Stall while tags or queue space fall short
    go = (|s2_v_q) && ({6'h00, need} <= (`INUM_CNT - infl_q))
         && ({2'h0, niq} <= iq_bus.space) && ({2'h0, nfq} <= fq_bus.space);
    stall = (|s2_v_q) && !go;
    iq_bus.enq_v = 4'h0;
    iq_bus.enq_tag = '0;
    iq_bus.enq_kind = {4{K_NOP}};
    fq_bus.enq_v = 4'h0;
    fq_bus.enq_tag = '0;
    fq_bus.enq_kind = {4{K_NOP}};
    iq_bus.hold = ex_hold_i;
    fq_bus.hold = ex_hold_i;
    for (int i = 0; i < 4; i++) begin
      if (s2_v_q[i]) begin
        // Sequential tags in program order, written in this cycle
        if (is_float(s2_kind_q[i])) begin
          fq_bus.enq_v[rf[1:0]] = go;
          fq_bus.enq_tag[rf[1:0]] = head_q + {5'h00, ri + rf};
          fq_bus.enq_kind[rf[1:0]] = s2_kind_q[i];
          rf = rf + 3'h1;
        end else begin
          iq_bus.enq_v[ri[1:0]] = go;
          iq_bus.enq_tag[ri[1:0]] = head_q + {5'h00, ri + rf};
          iq_bus.enq_kind[ri[1:0]] = s2_kind_q[i];
          ri = ri + 3'h1;
        end
      end
    end
    // Modulo-256 head; retirement frees oldest tags in order
    head_d = go ? head_q + {5'h00, need} : head_q;
    infl_d = infl_q + (go ? {6'h00, need} : 9'h000) - {6'h00, retire_cnt_i};
    s2_v_d = s2_v_q;
    s2_kind_d = s2_kind_q;
    s2_up_d = s2_up_q;
    if (!stall) begin
      s2_v_d = keep;
      s2_kind_d = s1_kind_q;
      // Upper or lower subcluster choice
      s2_up_d = slot_upper(keep, s1_res_q);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s2_v_q <= 4'h0;
      s2_kind_q <= {4{K_NOP}};
      s2_up_q <= 4'h0;
      head_q <= 8'h00;
      infl_q <= 9'h000;
    end else begin
      s2_v_q <= s2_v_d;
      s2_kind_q <= s2_kind_d;
      s2_up_q <= s2_up_d;
      head_q <= head_d;
      infl_q <= infl_d;
    end
  end

  assign slot_upper_o = s2_up_q;

  // Stages 3 to 6: issue, register read, execute, cache access
  assign s4_v = {fq_bus.iss_v[1:0], iq_bus.iss_v};
  assign s4_tag = {fq_bus.iss_tag[1:0], iq_bus.iss_tag};
  assign s4_kind = {fq_bus.iss_kind[1:0], iq_bus.iss_kind};
  assign rf_rd_o = s4_v;
  assign rf_tag_o = s4_tag;

  always_comb begin
    ex_v_d = s4_v;
    ex_tag_d = s4_tag;
    ex_kind_d = s4_kind;
    dc_v_d = ex_v_q;
    dc_tag_d = ex_tag_q;
    dc_kind_d = ex_kind_q;
    for (int i = 0; i < `EX_LANES; i++) begin
      // Bypassed result wins over the register file
      ex_op_d[i] = byp_hit_i[i] ? byp_data_i[i] : rf_data_i[i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ex_v_q <= '0;
      ex_tag_q <= '0;
      ex_kind_q <= {6{K_NOP}};
      ex_op_q <= '0;
      dc_v_q <= '0;
      dc_tag_q <= '0;
      dc_kind_q <= {6{K_NOP}};
    end else begin
      ex_v_q <= ex_v_d;
      ex_tag_q <= ex_tag_d;
      ex_kind_q <= ex_kind_d;
      ex_op_q <= ex_op_d;
      dc_v_q <= dc_v_d;
      dc_tag_q <= dc_tag_d;
      dc_kind_q <= dc_kind_d;
    end
  end

  assign ex_valid_o = ex_v_q;
  assign ex_opnd_o = ex_op_q;
  assign dc_inum_o = dc_tag_q;
  always_comb begin
    for (int i = 0; i < `EX_LANES; i++) begin
      // Loads: tag and data; stores: tag only, data to store queue
      sq_wr_o[i] = dc_v_q[i] && (dc_kind_q[i] == K_STORE || dc_kind_q[i] == K_FSTORE);
      dc_data_rd_o[i] = dc_v_q[i] && (dc_kind_q[i] == K_LOAD);
      dc_tag_rd_o[i] = dc_data_rd_o[i] || sq_wr_o[i];
      // Integer results written in stage 6
      wb_int_o[i] = dc_v_q[i] && (dc_kind_q[i] == K_INT);
    end
  end

  sequence s_mis;
    redir;
  endsequence
  sequence s_setmis;
    !stall && !redir && !miss_o && !hit_p;
  endsequence

  a_line_bubble: assert property (
    @(posedge clk_sys_i) disable iff (rst_i) s_mis |=> (s1_v_q == 4'h0))
    else $error("line mispredict did not leave one bubble");
  a_redirect_index: assert property (
    @(posedge clk_sys_i) disable iff (rst_i) s_mis |=> (ic_index_o == $past(bp_idx)))
    else $error("redirect did not use predictor index");
  a_fill_seed: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    ic_fill_i |-> lp_wr_o && (lp_wr_value_o == ic_fill_index_i + 11'h1))
    else $error("fill did not seed sequential line prediction");
  a_set_refetch: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    s_setmis |=> (s1_v_q[3:2] == 2'b00) && (ic_set_o != $past(ic_set_o))
                 && (ic_index_o == $past(ic_index_o)))
    else $error("set mispredict not refetched on other set");
  a_eell_slot: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    !stall && (s1_v_q == 4'hF) && (s1_br_q == 4'h0)
    && (s1_res_q == {RES_LOWER, RES_LOWER, RES_FLEX, RES_FLEX}) |=> (slot_upper_o == 4'h3))
    else $error("flex-flex-lower-lower not slotted upper-upper-lower-lower");
  a_tag_sequence: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    go |=> (head_q == $past(head_q) + 8'($past(need))))
    else $error("tag head did not advance by mapped count");
  a_tag_bound: assert property (
    @(posedge clk_sys_i) disable iff (rst_i) (infl_q <= `INUM_CNT) && (stall -> !go))
    else $error("in-flight tags exceed tag space");
  a_int_writeback: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    iq_bus.iss_v[0] && (iq_bus.iss_kind[0] == K_INT) |=> ##1 wb_int_o[0])
    else $error("integer result not written in stage 6");
  a_store_tag_only: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (|sq_wr_o) |-> ((dc_data_rd_o & sq_wr_o) == 6'h00) && ((dc_tag_rd_o & sq_wr_o) == sq_wr_o))
    else $error("store touched data array or skipped tag array");
endmodule

// File: rtl/fetch_defines.svh
/*
  Widths, depths and field positions of the fetch and issue pipeline.
  Assumes inclusion by bare name from the pipeline and issue queue files.
*/
`ifndef FETCH_DEFINES_SVH
`define FETCH_DEFINES_SVH
`define PC_W      48
`define RESET_PC  48'h0000_0000_0000
`define IDX_W     11
`define IDX_LSB   4
`define IDX_MSB   14
`define TAG_LSB   15
`define TAG_W     33
`define SLOTS     4
`define INUM_W    8
`define INUM_CNT  9'h100
`define IQ_DEPTH  20
`define IQ_ISSUE  4
`define FQ_DEPTH  15
`define FQ_ISSUE  2
`define XLEN      64
`define EX_LANES  6
`endif

// File: rtl/fetch_pkg.sv
/*
  Types shared by the fetch and issue pipeline and its issue queues.
  Assumes nothing of its surroundings.
*/
package fetch_pkg;
  typedef enum logic [1:0] {RES_FLEX, RES_UPPER, RES_LOWER, RES_NONE} res_t;
  typedef enum logic [2:0] {K_INT, K_LOAD, K_STORE, K_BRANCH,
                            K_FOP, K_FSTORE, K_FBRANCH, K_NOP} kind_t;
  typedef enum logic [1:0] {E_FREE, E_WAIT, E_ISSUED} entry_t;

  function automatic logic is_float(kind_t k);
    return (k == K_FOP) || (k == K_FSTORE) || (k == K_FBRANCH);
  endfunction
endpackage

// File: rtl/issue_if.sv
/*
  Carrier between the mapper and one issue queue.
  Enqueue lanes are packed from lane 0 upward; issue lanes likewise.
*/
`timescale 1ns/100ps
interface issue_if;
  import fetch_pkg::*;
  logic [3:0]      enq_v;
  logic [3:0][7:0] enq_tag;
  kind_t [3:0]     enq_kind;
  logic [4:0]      space;
  logic            hold;
  logic [3:0]      iss_v;
  logic [3:0][7:0] iss_tag;
  kind_t [3:0]     iss_kind;
  modport src (output enq_v, enq_tag, enq_kind, hold, input space, iss_v, iss_tag, iss_kind);
  modport q   (input enq_v, enq_tag, enq_kind, hold, output space, iss_v, iss_tag, iss_kind);
endinterface

// File: rtl/issue_queue.sv
/*
  Issue queue with delayed deletion of issued entries.
  Assumes the mapper never offers more entries than the space reported.
*/
`timescale 1ns/100ps
`include "fetch_defines.svh"
module issue_queue import fetch_pkg::*; #(
  parameter int DEPTH = `IQ_DEPTH,
  parameter int ISSUE = `IQ_ISSUE
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  issue_if.q        port_io
);
  entry_t          st_q   [DEPTH];
  entry_t          st_d   [DEPTH];
  logic [7:0]      tag_q  [DEPTH];
  logic [7:0]      tag_d  [DEPTH];
  kind_t           kind_q [DEPTH];
  kind_t           kind_d [DEPTH];
  logic [3:0]      iv_q;
  logic [3:0]      iv_d;
  logic [3:0][7:0] it_q;
  logic [3:0][7:0] it_d;
  kind_t [3:0]     ik_q;
  kind_t [3:0]     ik_d;
  logic [DEPTH-1:0] grant;
  logic [4:0]      nfree;

  always_comb begin
    int n;
    int e;
    n = 0;
    e = 0;
    nfree = '0;
    grant = '0;
    iv_d = '0;
    it_d = '0;
    ik_d = {4{K_NOP}};
    for (int i = 0; i < DEPTH; i++) begin
      st_d[i] = st_q[i];
      tag_d[i] = tag_q[i];
      kind_d[i] = kind_q[i];
      // Issued last cycle: present but silent, freed for the next cycle
      if (st_q[i] == E_ISSUED) begin
        st_d[i] = E_FREE;
      end
      // Up to ISSUE waiting entries leave per cycle
      if (st_q[i] == E_WAIT && !port_io.hold && n < ISSUE) begin
        grant[i] = 1'b1;
        st_d[i] = E_ISSUED;
        iv_d[n] = 1'b1;
        it_d[n] = tag_q[i];
        ik_d[n] = kind_q[i];
        n++;
      end
      if (st_q[i] == E_FREE) begin
        nfree = nfree + 5'h1;
        if (e < 4 && port_io.enq_v[e]) begin
          st_d[i] = E_WAIT;
          tag_d[i] = port_io.enq_tag[e];
          kind_d[i] = port_io.enq_kind[e];
          e++;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        st_q[i] <= E_FREE;
        tag_q[i] <= 8'h00;
        kind_q[i] <= K_NOP;
      end
      iv_q <= 4'h0;
      it_q <= '0;
      ik_q <= {4{K_NOP}};
    end else begin
      st_q <= st_d;
      tag_q <= tag_d;
      kind_q <= kind_d;
      iv_q <= iv_d;
      it_q <= it_d;
      ik_q <= ik_d;
    end
  end

  assign port_io.space = nfree;
  assign port_io.iss_v = iv_q;
  assign port_io.iss_tag = it_q;
  assign port_io.iss_kind = ik_q;

  sequence s_held(int k);
    (st_q[k] == E_ISSUED) && !grant[k] ##1 (st_q[k] == E_FREE);
  endsequence

  for (genvar g = 0; g < DEPTH; g++) begin : g_chk
    a_delayed_delete: assert property (
      @(posedge clk_sys_i) disable iff (rst_i) grant[g] |=> s_held(g))
      else $error("issued entry not deleted two cycles later");
  end

  a_issue_width: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    ($countones(port_io.iss_v) <= ISSUE) && (port_io.iss_v[0] || !port_io.iss_v[1]))
    else $error("issue lanes exceed queue width or are not packed");
endmodule

// File: testbench/exec_partner.sv
/* Far-side model: register files, bypass network and retirement.
   Assumes it shares the pipeline clock and sees the stage outputs. */
`timescale 1ns/100ps
module exec_partner (
  input  wire logic            clk_sys_i,
  input  wire logic [5:0]      rf_rd_i,
  input  wire logic [5:0][7:0] rf_tag_i,
  input  wire logic [5:0]      done_i,
  output logic [5:0][63:0]     rf_data_o,
  output logic [5:0]           byp_hit_o,
  output logic [5:0][63:0]     byp_data_o,
  output logic [2:0]           retire_cnt_o
);
  initial begin
    rf_data_o = '0;
    byp_hit_o = '0;
    byp_data_o = '0;
    retire_cnt_o = 3'h0;
  end
  // Unread lanes toggle so stale operands never look valid
  always @(negedge clk_sys_i) begin
    for (int l = 0; l < 6; l++) begin
      rf_data_o[l] <= rf_rd_i[l] ? {8{rf_tag_i[l]}} : ~rf_data_o[l];
      byp_hit_o[l] <= rf_rd_i[l] & l[0];
      byp_data_o[l] <= rf_rd_i[l] ? {8{~rf_tag_i[l]}} : ~byp_data_o[l];
    end
    retire_cnt_o <= ($countones(done_i) > 4) ? 3'h4 : 3'($countones(done_i));
  end
endmodule

// File: testbench/test_superscalar_fetch_issue_pipeline.sv
/* Bench for the fetch and issue pipeline.
   Assumes the design files and the far-side model compile first. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module test_superscalar_fetch_issue_pipeline import fetch_pkg::*; ();
  logic             clk_sys_i = 1'b0, rst_i = 1'b1, manual = 1'b1;
  logic             ic_fill_i = 1'b0, ic_set_pred_i = 1'b0, ex_hold_i = 1'b0;
  logic             bp_taken_i = 1'b0;
  logic [3:0]       ic_branch_i = 4'h0;
  logic [47:0]      bp_target_i = '0;
  logic [5:0][7:0]  tq1 = '0, tq2 = '0;
  logic [32:0]      ic_tag0_i = 33'h1_5555_5555, ic_tag1_i = 33'h0_AAAA_AAAA;
  logic [10:0]      ic_line_pred_i = '0, ic_fill_index_i = '0, held;
  kind_t [3:0]      ic_kind_i = {K_INT, K_STORE, K_LOAD, K_INT};
  res_t [3:0]       ic_res_i = {RES_LOWER, RES_LOWER, RES_FLEX, RES_FLEX};
  logic [10:0]      ic_index_o, lp_wr_index_o, lp_wr_value_o, sp_wr_index_o;
  logic             ic_set_o, miss_o, lp_wr_o, sp_wr_o, sp_wr_set_o;
  logic [47:0]      virtual_fetch_pc_o;
  logic [3:0]       slot_upper_o;
  logic [2:0]       retire_cnt_i;
  logic [5:0]       rf_rd_o, ex_valid_o, dc_tag_rd_o, dc_data_rd_o, sq_wr_o, wb_int_o;
  logic [5:0]       byp_hit_i, rd_q = '0, rd_qq = '0;
  logic [5:0][7:0]  rf_tag_o, dc_inum_o;
  logic [5:0][63:0] rf_data_i, byp_data_i, ex_opnd_o, opnd_q;
  logic [255:0]     issued = '0;
  int               mismatches = 0, comparisons = 0, cycles = 0, loads = 0, stores = 0;
  int               first = 1;

  fetch_issue_pipeline DUT (.*, .ic_lp_true_i(1'b0), .ic_jump_to_subroutine_i(4'h0));
  exec_partner far_end (.clk_sys_i(clk_sys_i), .rf_rd_i(rf_rd_o), .rf_tag_i(rf_tag_o),
    .done_i(dc_tag_rd_o | wb_int_o), .rf_data_o(rf_data_i), .byp_hit_o(byp_hit_i),
    .byp_data_o(byp_data_i), .retire_cnt_o(retire_cnt_i));

  always #5 clk_sys_i = ~clk_sys_i;

  // Cache model: hit in the predicted set, line prediction is the next line
  always @(negedge clk_sys_i) if (!manual) begin
    ic_tag0_i = ic_set_o ? ~virtual_fetch_pc_o[47:15] : virtual_fetch_pc_o[47:15];
    ic_tag1_i = ~ic_tag0_i;
    ic_line_pred_i = ic_index_o + 11'h001;
  end

  always @(negedge clk_sys_i) if (!rst_i) begin
    `CHK("ex_valid", rd_q, ex_valid_o)
    `CHK("stage6", rd_qq, dc_tag_rd_o | wb_int_o)
    for (int l = 0; l < 6; l++) begin
      if (rd_q[l]) `CHK("ex_opnd", opnd_q[l], ex_opnd_o[l])
      if (rd_qq[l]) `CHK("dc_inum", tq2[l], dc_inum_o[l])
      if (rf_rd_o[l]) begin
        `CHK("tag reuse", 1'b0, issued[rf_tag_o[l]])
        if (first) `CHK("first tag", 8'h00, rf_tag_o[l])
        first = 0;
        issued[rf_tag_o[l]] = 1'b1;
        issued[8'(rf_tag_o[l] + 8'h80)] = 1'b0;
        opnd_q[l] = l[0] ? {8{~rf_tag_o[l]}} : {8{rf_tag_o[l]}};
      end
      loads += dc_data_rd_o[l];
      stores += sq_wr_o[l];
      if (dc_data_rd_o[l] | sq_wr_o[l])
        `CHK("dc strobes", {1'b1, sq_wr_o[l]}, {dc_tag_rd_o[l], ~dc_data_rd_o[l]})
    end
    rd_qq = rd_q;
    rd_q = rf_rd_o;
    tq2 = tq1;
    tq1 = rf_tag_o;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic t_reset();
    repeat (16) @(negedge clk_sys_i);
    `CHK("reset pc", 48'h0, virtual_fetch_pc_o)
    `CHK("reset strobes", 6'h00, rf_rd_o | wb_int_o | sq_wr_o)
    rst_i = 1'b0;
    $display("test reset done");
  endtask

  task automatic t_fill();
    held = ic_index_o;
    ic_fill_i = 1'b1;
    ic_fill_index_i = 11'h07F;
    #1 `CHK("miss", 1'b1, miss_o)
    `CHK("fill", {1'b1, 11'h07F, 11'h080}, {lp_wr_o, lp_wr_index_o, lp_wr_value_o})
    @(negedge clk_sys_i) ic_fill_i = 1'b0;
    `CHK("held index", held, ic_index_o)
    ic_tag1_i = virtual_fetch_pc_o[47:15];
    #1 `CHK("set retrain", {2'b11, held}, {sp_wr_o, sp_wr_set_o, sp_wr_index_o})
    @(negedge clk_sys_i);
    `CHK("set flip", {1'b1, held}, {ic_set_o, ic_index_o})
    manual = 1'b0;
    $display("test fill and set done");
  endtask

  task automatic t_flow();
    logic seen;
    seen = 1'b0;
    repeat (30) @(negedge clk_sys_i);
    `CHK("slotting", 4'h3, slot_upper_o)
    ex_hold_i = 1'b1;
    repeat (30) @(negedge clk_sys_i);
    held = ic_index_o;
    @(negedge clk_sys_i);
    `CHK("full stall", {held, 6'h00}, {ic_index_o, rf_rd_o})
    ex_hold_i = 1'b0;
    repeat (3) @(negedge clk_sys_i) seen |= (rf_rd_o === 6'h0F);
    `CHK("four issue", 1'b1, seen)
    repeat (10) @(negedge clk_sys_i);
    `CHK("loads stores", 1'b1, loads > 0 && stores > 0)
    $display("test flow done");
  endtask

  task automatic t_branch();
    logic [10:0] x;
    @(negedge clk_sys_i);
    x = ic_index_o;
    ic_branch_i = 4'h6;
    @(negedge clk_sys_i);
    `CHK("walk retrain", {1'b1, x}, {lp_wr_o, lp_wr_value_o})
    @(negedge clk_sys_i);
    `CHK("walk refetch", x, ic_index_o)
    @(negedge clk_sys_i);
    `CHK("next line", x + 11'h1, ic_index_o)
    bp_taken_i = 1'b1;
    bp_target_i = {33'h0, x + 11'h3, 4'h0};
    @(negedge clk_sys_i);
    `CHK("taken target", x + 11'h3, ic_index_o)
    ic_branch_i = 4'h0;
    bp_taken_i = 1'b0;
    $display("test branch done");
  endtask

  initial begin
    t_reset();
    t_fill();
    t_flow();
    t_branch();
    give_verdict();
  end
endmodule
